// >>> hw/eam_pkg.sv
// energy accumulation mode and no-load package: register map, fields, codes
// assumes one core clock domain and a plain address/strobe register port
package eam_pkg;

  // ==========================================================================
  // widths
  localparam int PWR_W  = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int THR_W  = 16;
  localparam int NPH    = 3;

  // ==========================================================================
  // register offsets (word index on the register port)
  localparam logic [ADDR_W-1:0] ADR_ACC_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_STAT0   = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_FIRST_INTERRUPT_MASK   = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_SIGN    = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_STAT1   = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_SECOND_INTERRUPT_MASK   = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_NLPH    = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_APNL    = 4'h7;
  localparam logic [ADDR_W-1:0] ADR_VANL    = 4'h8;

  // ==========================================================================
  // field positions
  localparam int ACT_MODE_LSB   = 0;
  localparam int REACT_MODE_LSB = 2;
  localparam int REV_POS  [NPH] = '{9, 13, 18};
  localparam int SIGN_POS [NPH] = '{3, 7, 8};
  localparam int NL_FLAG_BIT    = 0;
  localparam int NL_PHASE_LSB   = 0;

  // ==========================================================================
  // accumulation mode codes
  localparam logic [1:0] ACT_SIGNED     = 2'h0;
  localparam logic [1:0] ACT_POS_ONLY   = 2'h1;
  localparam logic [1:0] ACT_RSVD       = 2'h2;
  localparam logic [1:0] ACT_ABS        = 2'h3;
  localparam logic [1:0] REACT_SIGNED   = 2'h0;
  localparam logic [1:0] REACT_RSVD     = 2'h1;
  localparam logic [1:0] REACT_SIGN_ADJ = 2'h2;
  localparam logic [1:0] REACT_ABS      = 2'h3;

  // ==========================================================================
  // reset values and counts
  localparam logic [1:0]       MODE_RST = 2'h0;
  localparam logic [NPH-1:0]   MASK_RST = 3'h0;
  localparam logic [THR_W-1:0] THR_RST  = 16'h0000;
  localparam logic [THR_W-1:0] CNT_MAX  = 16'hFFFF;

endpackage

// >>> hw/eam_core.sv
// energy accumulation policy, sum-sign reversal and total/apparent no-load
// assumes power samples, stage events and pulse edges come from core-clock logic
`timescale 1ns/10ps

module eam_core
  import eam_pkg::*;
(
  input  wire  logic                                         CORE_CLK,
  input  wire  logic                                         ARST_N,
  input  wire  logic [eam_pkg::ADDR_W-1:0]                   ADDR,
  input  wire  logic [eam_pkg::DATA_W-1:0]                   WR_DATA,
  input  wire  logic                                         WR_STB,
  input  wire  logic                                         RD_STB,
  output logic       [eam_pkg::DATA_W-1:0]                   RD_DATA,
  input  wire  logic                                         SAMPLE_VALID,
  input  wire  logic [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  TOT_ACT_PWR,
  input  wire  logic [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  FUND_ACT_PWR,
  input  wire  logic [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  FUND_REACT_PWR,
  input  wire  logic [eam_pkg::NPH-1:0]                      FUND_NOLOAD,
  input  wire  logic [eam_pkg::NPH-1:0]                      ACT_LSB,
  input  wire  logic [eam_pkg::NPH-1:0]                      VA_LSB,
  input  wire  logic [eam_pkg::NPH-1:0]                      STAGE_EVT,
  input  wire  logic [eam_pkg::NPH-1:0]                      STAGE_SUM_NEG,
  input  wire  logic [eam_pkg::NPH-1:0]                      CF_FALL,
  output logic                                               ACC_VALID,
  output logic       [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  WH_INC,
  output logic       [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  FWH_INC,
  output logic       [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  FVARH_INC,
  output logic       [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  CF_TACT,
  output logic       [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  CF_FACT,
  output logic       [eam_pkg::NPH-1:0][eam_pkg::PWR_W-1:0]  CF_FVAR,
  output logic       [eam_pkg::NPH-1:0]                      NOLOAD_PH,
  output logic                                               FIRST_INTERRUPT_PIN_N_N,
  output logic                                               SECOND_INTERRUPT_PIN_N_N
);
  import eam_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0]                 act_mode;
    logic [1:0]                 react_mode;
    logic [NPH-1:0]             rev;
    logic [NPH-1:0]             sign;
    logic [NPH-1:0]             pend;
    logic [NPH-1:0]             pend_sign;
    logic [NPH-1:0]             last_sign;
    logic [NPH-1:0]             first_interrupt_mask;
    logic                       second_interrupt_mask;
    logic                       nl_flag;
    logic [NPH-1:0]             nl;
    logic [THR_W-1:0]           ap_thr;
    logic [THR_W-1:0]           va_thr;
    logic [NPH-1:0][THR_W-1:0]  act_cnt;
    logic [NPH-1:0][THR_W-1:0]  va_cnt;
    logic                       acc_valid;
    logic [NPH-1:0][PWR_W-1:0]  wh;
    logic [NPH-1:0][PWR_W-1:0]  fwh;
    logic [NPH-1:0][PWR_W-1:0]  fvarh;
    logic [NPH-1:0][PWR_W-1:0]  cf_tact;
    logic [NPH-1:0][PWR_W-1:0]  cf_fact;
    logic [NPH-1:0][PWR_W-1:0]  cf_fvar;
    logic [DATA_W-1:0]          rd_data;
    logic                       first_interrupt_pin_n_n;
    logic                       second_interrupt_pin_n_n;
  } eam_state_t;

  eam_state_t st;
  eam_state_t next_st;
  logic       rst_meta;
  logic       rst_n;

  // ==========================================================================
  // helpers
  function automatic logic [PWR_W-1:0] negate(input logic [PWR_W-1:0] v);
    negate = PWR_W'(~v + 1'b1);
  endfunction

  function automatic logic [PWR_W-1:0] mag(input logic [PWR_W-1:0] v);
    mag = v[PWR_W-1] ? negate(v) : v;
  endfunction

  // active feed; to_reg selects the watt-hour path, else the pulse path
  function automatic logic [PWR_W-1:0] act_feed(input logic [1:0] mode, input logic [PWR_W-1:0] v,
                                                input logic to_reg);
    case (mode)
      ACT_POS_ONLY: act_feed = (to_reg && v[PWR_W-1]) ? '0 : v;
      ACT_ABS:      act_feed = mag(v);
      default:      act_feed = v;
    endcase
  endfunction

  function automatic logic [PWR_W-1:0] react_feed(input logic [1:0] mode, input logic [PWR_W-1:0] v,
                                                  input logic act_neg, input logic to_reg);
    case (mode)
      REACT_SIGN_ADJ: react_feed = act_neg ? negate(v) : v;
      REACT_ABS:      react_feed = to_reg ? mag(v) : v;
      default:        react_feed = v;
    endcase
  endfunction

  // ==========================================================================
  // reset release; assertion is immediate, release waits two clocks
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    logic           wr_stat0;
    logic           wr_stat1;
    logic           ap_en;
    logic           va_en;
    logic           a_idle;
    logic           v_idle;
    logic           fa_neg;
    logic [NPH-1:0] nl_new;
    wr_stat0 = 1'b0;
    wr_stat1 = 1'b0;
    ap_en    = 1'b0;
    va_en    = 1'b0;
    a_idle   = 1'b0;
    v_idle   = 1'b0;
    fa_neg   = 1'b0;
    nl_new   = '0;
    next_st  = st;

    // register writes
    if (WR_STB) begin
      if (ADDR == ADR_ACC_CFG) begin
        next_st.act_mode   = WR_DATA[ACT_MODE_LSB +: 2];
        next_st.react_mode = WR_DATA[REACT_MODE_LSB +: 2];
      end else if (ADDR == ADR_STAT0) begin
        wr_stat0 = 1'b1;
      end else if (ADDR == ADR_FIRST_INTERRUPT_MASK) begin
        for (int i = 0; i < NPH; i++) begin
          next_st.first_interrupt_mask[i] = WR_DATA[REV_POS[i]];
        end
      end else if (ADDR == ADR_STAT1) begin
        wr_stat1 = 1'b1;
      end else if (ADDR == ADR_SECOND_INTERRUPT_MASK) begin
        next_st.second_interrupt_mask = WR_DATA[NL_FLAG_BIT];
      end else if (ADDR == ADR_APNL) begin
        next_st.ap_thr = WR_DATA[THR_W-1:0];
      end else if (ADDR == ADR_VANL) begin
        next_st.va_thr = WR_DATA[THR_W-1:0];
      end
    end

    // write-1 clear first, so an event in the same cycle sets it again
    for (int i = 0; i < NPH; i++) begin
      if (wr_stat0 && WR_DATA[REV_POS[i]]) begin
        next_st.rev[i] = 1'b0;
      end
    end
    if (wr_stat1 && WR_DATA[NL_FLAG_BIT]) begin
      next_st.nl_flag = 1'b0;
    end

    // sum sign tracking per pulse path
    for (int i = 0; i < NPH; i++) begin
      // the converter edge is taken whether or not its pin is enabled
      if (CF_FALL[i] && st.pend[i]) begin
        next_st.rev[i]  = 1'b1;
        next_st.sign[i] = st.pend_sign[i];
        next_st.pend[i] = 1'b0;
      end
      if (STAGE_EVT[i] && (STAGE_SUM_NEG[i] != st.last_sign[i])) begin
        next_st.pend[i]      = 1'b1;
        next_st.pend_sign[i] = STAGE_SUM_NEG[i];
      end
      if (STAGE_EVT[i]) begin
        next_st.last_sign[i] = STAGE_SUM_NEG[i];
      end
    end

    // no-load idle timers and decision
    ap_en = (st.ap_thr != '0);
    va_en = (st.va_thr != '0);
    for (int p = 0; p < NPH; p++) begin
      if (ACT_LSB[p]) begin
        next_st.act_cnt[p] = '0;
      end else if (SAMPLE_VALID && (st.act_cnt[p] != CNT_MAX)) begin
        next_st.act_cnt[p] = st.act_cnt[p] + 1'b1;
      end
      if (VA_LSB[p]) begin
        next_st.va_cnt[p] = '0;
      end else if (SAMPLE_VALID && (st.va_cnt[p] != CNT_MAX)) begin
        next_st.va_cnt[p] = st.va_cnt[p] + 1'b1;
      end
      a_idle    = (st.act_cnt[p] >= st.ap_thr);
      v_idle    = (st.va_cnt[p] >= st.va_thr);
      // a zero threshold drops its term; both zero turns detection off
      nl_new[p] = (ap_en || va_en) && (!ap_en || a_idle) && (!va_en || v_idle);
    end
    next_st.nl = nl_new;
    if (nl_new != st.nl) begin
      next_st.nl_flag = 1'b1;
    end

    // accumulation feeds, refreshed per sample
    next_st.acc_valid = SAMPLE_VALID;
    if (SAMPLE_VALID) begin
      for (int p = 0; p < NPH; p++) begin
        next_st.fwh[p]     = act_feed(st.act_mode, FUND_ACT_PWR[p], 1'b1);
        next_st.cf_fact[p] = act_feed(st.act_mode, FUND_ACT_PWR[p], 1'b0);
        if (st.nl[p]) begin
          next_st.wh[p]      = '0;
          next_st.cf_tact[p] = '0;
        end else begin
          next_st.wh[p]      = act_feed(st.act_mode, TOT_ACT_PWR[p], 1'b1);
          next_st.cf_tact[p] = act_feed(st.act_mode, TOT_ACT_PWR[p], 1'b0);
        end
        // fundamental active below its own no-load level counts as zero
        fa_neg = FUND_ACT_PWR[p][PWR_W-1] && !FUND_NOLOAD[p];
        next_st.fvarh[p]   = react_feed(st.react_mode, FUND_REACT_PWR[p], fa_neg, 1'b1);
        next_st.cf_fvar[p] = react_feed(st.react_mode, FUND_REACT_PWR[p], fa_neg, 1'b0);
      end
    end

    // read data stands one cycle only
    next_st.rd_data = '0;
    if (RD_STB) begin
      if (ADDR == ADR_ACC_CFG) begin
        next_st.rd_data[ACT_MODE_LSB +: 2]   = st.act_mode;
        next_st.rd_data[REACT_MODE_LSB +: 2] = st.react_mode;
      end else if (ADDR == ADR_STAT0) begin
        for (int i = 0; i < NPH; i++) begin
          next_st.rd_data[REV_POS[i]] = st.rev[i];
        end
      end else if (ADDR == ADR_FIRST_INTERRUPT_MASK) begin
        for (int i = 0; i < NPH; i++) begin
          next_st.rd_data[REV_POS[i]] = st.first_interrupt_mask[i];
        end
      end else if (ADDR == ADR_SIGN) begin
        for (int i = 0; i < NPH; i++) begin
          next_st.rd_data[SIGN_POS[i]] = st.sign[i];
        end
      end else if (ADDR == ADR_STAT1) begin
        next_st.rd_data[NL_FLAG_BIT] = st.nl_flag;
      end else if (ADDR == ADR_SECOND_INTERRUPT_MASK) begin
        next_st.rd_data[NL_FLAG_BIT] = st.second_interrupt_mask;
      end else if (ADDR == ADR_NLPH) begin
        next_st.rd_data[NL_PHASE_LSB +: NPH] = st.nl;
      end else if (ADDR == ADR_APNL) begin
        next_st.rd_data[THR_W-1:0] = st.ap_thr;
      end else if (ADDR == ADR_VANL) begin
        next_st.rd_data[THR_W-1:0] = st.va_thr;
      end
    end

    // pins follow the flags they gate, low while any enabled flag stays set
    next_st.first_interrupt_pin_n_n = ~|(next_st.rev & next_st.first_interrupt_mask);
    next_st.second_interrupt_pin_n_n = ~(next_st.nl_flag & next_st.second_interrupt_mask);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st            <= '0;
      st.act_mode   <= MODE_RST;
      st.react_mode <= MODE_RST;
      st.first_interrupt_mask      <= MASK_RST;
      st.ap_thr     <= THR_RST;
      st.va_thr     <= THR_RST;
      st.first_interrupt_pin_n_n     <= 1'b1;
      st.second_interrupt_pin_n_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign RD_DATA   = st.rd_data;
  assign ACC_VALID = st.acc_valid;
  assign WH_INC    = st.wh;
  assign FWH_INC   = st.fwh;
  assign FVARH_INC = st.fvarh;
  assign CF_TACT   = st.cf_tact;
  assign CF_FACT   = st.cf_fact;
  assign CF_FVAR   = st.cf_fvar;
  assign NOLOAD_PH = st.nl;
  assign FIRST_INTERRUPT_PIN_N_N    = st.first_interrupt_pin_n_n;
  assign SECOND_INTERRUPT_PIN_N_N    = st.second_interrupt_pin_n_n;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n);

  act_signed_a: assert property ((SAMPLE_VALID && !st.act_mode[0] && !st.nl[0]) |=>
    (WH_INC[0] == $past(TOT_ACT_PWR[0])) && (CF_TACT[0] == $past(TOT_ACT_PWR[0])))
    else $error("signed active feed differs from sample");

  act_posonly_a: assert property ((SAMPLE_VALID && st.act_mode == ACT_POS_ONLY && !st.nl[0]
    && TOT_ACT_PWR[0][PWR_W-1]) |=> (WH_INC[0] == '0) && (CF_TACT[0] == $past(TOT_ACT_PWR[0])))
    else $error("positive-only mode passed negative energy");

  act_abs_a: assert property ((SAMPLE_VALID && st.act_mode == ACT_ABS && FUND_ACT_PWR[1][PWR_W-1])
    |=> (FWH_INC[1] == negate($past(FUND_ACT_PWR[1]))) && (CF_FACT[1] == FWH_INC[1]))
    else $error("absolute mode did not negate");

  react_adj_a: assert property ((SAMPLE_VALID && st.react_mode == REACT_SIGN_ADJ
    && FUND_ACT_PWR[2][PWR_W-1] && !FUND_NOLOAD[2])
    |=> FVARH_INC[2] == negate($past(FUND_REACT_PWR[2])))
    else $error("sign adjust missed negative active");

  react_abs_a: assert property ((SAMPLE_VALID && st.react_mode == REACT_ABS) |=>
    (FVARH_INC[0] == mag($past(FUND_REACT_PWR[0]))) && (CF_FVAR[0] == $past(FUND_REACT_PWR[0])))
    else $error("absolute reactive paths wrong");

  rev_set_a: assert property ((CF_FALL[1] && st.pend[1]) |=>
    st.rev[1] && (st.sign[1] == $past(st.pend_sign[1])) && (!st.first_interrupt_mask[1] || !FIRST_INTERRUPT_PIN_N_N))
    else $error("reversal flag not set at pulse fall");

  rev_hold_a: assert property ((STAGE_EVT[0] && STAGE_SUM_NEG[0] != st.last_sign[0]
    && !CF_FALL[0]) |=> st.pend[0] && (st.pend_sign[0] == $past(STAGE_SUM_NEG[0])) && !(st.rev[0] && !$past(st.rev[0])))
    else $error("sign change not held for pulse");

  first_interrupt_pin_n_low_a: assert property ((st.rev[2] && st.first_interrupt_mask[2]) |-> !FIRST_INTERRUPT_PIN_N_N)
    else $error("first irq not low for masked flag");

  rev_clr_a: assert property ((WR_STB && ADDR == ADR_STAT0 && WR_DATA[REV_POS[0]]
    && !(CF_FALL[0] && st.pend[0])) |=> !st.rev[0])
    else $error("write one did not clear reversal");

  nl_gate_a: assert property ((SAMPLE_VALID && st.nl[2]) |=> (WH_INC[2] == '0) && (CF_TACT[2] == '0))
    else $error("no-load phase still accumulated");

  nl_off_a: assert property ((st.ap_thr == '0 && st.va_thr == '0) [*2] |-> st.nl == '0)
    else $error("detector active with zero thresholds");

  nl_flag_a: assert property ((st.nl != $past(st.nl)) |-> st.nl_flag && (SECOND_INTERRUPT_PIN_N_N == !st.second_interrupt_mask))
    else $error("no-load change not flagged");

endmodule

// >>> verif/eam_host.sv
// host model: register port master that services status and mask words
// assumes strobes are sampled on rising clk and read data stands one cycle later
`timescale 1ns/10ps

// ============================================================================
// host bus master
module eam_host
  import eam_pkg::*;
(
  input  wire  logic                        clk,
  output logic       [eam_pkg::ADDR_W-1:0]  addr,
  output logic       [eam_pkg::DATA_W-1:0]  wdata,
  output logic                              wstb,
  output logic                              rstb,
  input  wire  logic [eam_pkg::DATA_W-1:0]  rdata
);
  initial begin
    addr = '0;
    wdata = '0;
    wstb = 1'b0;
    rstb = 1'b0;
  end

  // status clears are plain writes with the flag bit set
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge, so it is caught just after that edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the accumulation mode, sum-sign and no-load block
// assumes eam_pkg and the host model are compiled first
`timescale 1ns/10ps

module testbench;
  import eam_pkg::*;
  // ==========================================================================
  // signals
  localparam logic [31:0] P5 = 32'h00000005;
  localparam logic [31:0] N5 = 32'h00FFFFFB;
  localparam logic [31:0] P7 = 32'h00000007;
  localparam logic [31:0] N7 = 32'h00FFFFF9;
  localparam logic [31:0] P3 = 32'h00000003;
  localparam logic [31:0] N3 = 32'h00FFFFFD;
  logic                           core_clk = 1'b0;
  logic                           arst_n = 1'b0;
  logic [ADDR_W-1:0]              addr;
  logic [DATA_W-1:0]              wdata;
  logic [DATA_W-1:0]              rdata;
  logic [DATA_W-1:0]              rv;
  logic                           wstb;
  logic                           rstb;
  logic                           sample_valid = 1'b0;
  logic [NPH-1:0][PWR_W-1:0]      tot_act = {3{24'hFFFFFB}};
  logic [NPH-1:0][PWR_W-1:0]      fund_act = {3{24'hFFFFF9}};
  logic [NPH-1:0][PWR_W-1:0]      fund_react = {3{24'hFFFFFD}};
  logic [NPH-1:0]                 fund_noload = 3'h0;
  logic [NPH-1:0]                 act_lsb = 3'h0;
  logic [NPH-1:0]                 va_lsb = 3'h0;
  logic [NPH-1:0]                 stage_evt = 3'h0;
  logic [NPH-1:0]                 stage_neg = 3'h0;
  logic [NPH-1:0]                 cf_fall = 3'h0;
  logic                           acc_valid;
  logic [NPH-1:0][PWR_W-1:0]      wh_inc;
  logic [NPH-1:0][PWR_W-1:0]      fwh_inc;
  logic [NPH-1:0][PWR_W-1:0]      fvarh_inc;
  logic [NPH-1:0][PWR_W-1:0]      cf_tact;
  logic [NPH-1:0][PWR_W-1:0]      cf_fact;
  logic [NPH-1:0][PWR_W-1:0]      cf_fvar;
  logic [NPH-1:0]                 noload_ph;
  logic                           first_interrupt_pin_n_n;
  logic                           second_interrupt_pin_n_n;
  logic [31:0]                    sgn;
  int                             n_fail = 0;
  int                             compares = 0;

  // ==========================================================================
  // design and host
  always #12.5 core_clk = ~core_clk;

  eam_core eam_core_inst (.CORE_CLK(core_clk), .ARST_N(arst_n), .ADDR(addr), .WR_DATA(wdata), .WR_STB(wstb),
    .RD_STB(rstb), .RD_DATA(rdata), .SAMPLE_VALID(sample_valid), .TOT_ACT_PWR(tot_act), .FUND_ACT_PWR(fund_act),
    .FUND_REACT_PWR(fund_react), .FUND_NOLOAD(fund_noload), .ACT_LSB(act_lsb), .VA_LSB(va_lsb),
    .STAGE_EVT(stage_evt), .STAGE_SUM_NEG(stage_neg), .CF_FALL(cf_fall), .ACC_VALID(acc_valid),
    .WH_INC(wh_inc), .FWH_INC(fwh_inc), .FVARH_INC(fvarh_inc), .CF_TACT(cf_tact), .CF_FACT(cf_fact),
    .CF_FVAR(cf_fvar), .NOLOAD_PH(noload_ph), .FIRST_INTERRUPT_PIN_N_N(first_interrupt_pin_n_n), .SECOND_INTERRUPT_PIN_N_N(second_interrupt_pin_n_n));

  eam_host eam_host_inst (.clk(core_clk), .addr(addr), .wdata(wdata), .wstb(wstb), .rstb(rstb), .rdata(rdata));

  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    eam_host_inst.rd(a, rv);
    chk(nm, rv, exp);
  endtask

  // one sample, increments land at the sampling edge
  task automatic sample();
    @(posedge core_clk);
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    #1;
    chk("acc_valid", {31'h0, acc_valid}, 32'h1);
  endtask

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang is cut short here
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  // ==========================================================================
  // scenarios
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("irq pins", {30'h0, second_interrupt_pin_n_n, first_interrupt_pin_n_n}, 32'h3);
    eam_host_inst.wr(ADR_SIGN, 32'hFFFFFFFF);
    rchk("sign ro", ADR_SIGN, 32'h0);
    eam_host_inst.wr(4'hF, 32'hFFFFFFFF);
    rchk("unmapped", 4'hF, 32'h0);
    // every active and reactive code, negative powers everywhere
    for (int m = 0; m < 4; m++) begin
      eam_host_inst.wr(ADR_ACC_CFG, 32'(m * 5));
      sample();
      chk("wh_inc", {8'h00, wh_inc[0]}, (m == 1) ? 32'h0 : (m == 3) ? P5 : N5);
      chk("cf_tact", {8'h00, cf_tact[2]}, (m == 3) ? P5 : N5);
      chk("fwh_inc", {8'h00, fwh_inc[1]}, (m == 1) ? 32'h0 : (m == 3) ? P7 : N7);
      chk("cf_fact", {8'h00, cf_fact[0]}, (m == 3) ? P7 : N7);
      chk("fvarh_inc", {8'h00, fvarh_inc[0]}, (m >= 2) ? P3 : N3);
      chk("cf_fvar", {8'h00, cf_fvar[1]}, (m == 2) ? P3 : N3);
    end
    // fundamental below its no-load level counts as zero, no sign change
    fund_noload <= 3'h1;
    eam_host_inst.wr(ADR_ACC_CFG, 32'h8);
    sample();
    chk("fvarh_inc", {8'h00, fvarh_inc[0]}, N3);
    chk("fvarh_inc", {8'h00, fvarh_inc[1]}, P3);
    fund_noload <= 3'h0;
    // sum reversal on each path, flag and sign only at the next pulse fall
    eam_host_inst.wr(ADR_FIRST_INTERRUPT_MASK, 32'h00042200);
    sgn = 32'h0;
    for (int i = 0; i < NPH; i++) begin
      @(posedge core_clk);
      stage_evt[i] <= 1'b1;
      stage_neg[i] <= 1'b1;
      @(posedge core_clk);
      stage_evt[i] <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("first_interrupt_pin_n_n early", {31'h0, first_interrupt_pin_n_n}, 32'h1);
      cf_fall[i] <= 1'b1;
      @(posedge core_clk);
      cf_fall[i] <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("first_interrupt_pin_n_n", {31'h0, first_interrupt_pin_n_n}, 32'h0);
      sgn[SIGN_POS[i]] = 1'b1;
      rchk("first_status_register", ADR_STAT0, 32'h1 << REV_POS[i]);
      rchk("sign", ADR_SIGN, sgn);
      eam_host_inst.wr(ADR_STAT0, 32'h1 << REV_POS[i]);
      rchk("first_status_register clr", ADR_STAT0, 32'h0);
      chk("first_interrupt_pin_n_n clr", {31'h0, first_interrupt_pin_n_n}, 32'h1);
    end
    @(posedge core_clk);
    cf_fall[0] <= 1'b1;
    @(posedge core_clk);
    cf_fall[0] <= 1'b0;
    rchk("no pending", ADR_STAT0, 32'h0);
    // no-load on active timer alone, blocks total active only
    eam_host_inst.wr(ADR_ACC_CFG, 32'h0);
    eam_host_inst.wr(ADR_SECOND_INTERRUPT_MASK, 32'h1);
    eam_host_inst.wr(ADR_APNL, 32'h2);
    sample();
    sample();
    chk("noload_ph", {29'h0, noload_ph}, 32'h7);
    chk("second_interrupt_pin_n_n", {31'h0, second_interrupt_pin_n_n}, 32'h0);
    chk("wh_inc nl", {8'h00, wh_inc[0]}, 32'h0);
    chk("cf_tact nl", {8'h00, cf_tact[0]}, 32'h0);
    chk("fwh_inc nl", {8'h00, fwh_inc[0]}, N7);
    rchk("second_status_register", ADR_STAT1, 32'h1);
    rchk("phase nl", ADR_NLPH, 32'h7);
    eam_host_inst.wr(ADR_STAT1, 32'h1);
    #1;
    chk("second_interrupt_pin_n_n clr", {31'h0, second_interrupt_pin_n_n}, 32'h1);
    @(posedge core_clk);
    act_lsb[0] <= 1'b1;
    @(posedge core_clk);
    act_lsb[0] <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("noload exit", {29'h0, noload_ph}, 32'h6);
    rchk("second_status_register exit", ADR_STAT1, 32'h1);
    eam_host_inst.wr(ADR_STAT1, 32'h1);
    // apparent timer alone, then both zero turns the detector off
    eam_host_inst.wr(ADR_APNL, 32'h0);
    eam_host_inst.wr(ADR_VANL, 32'h2);
    sample();
    sample();
    chk("noload va", {29'h0, noload_ph}, 32'h7);
    @(posedge core_clk);
    va_lsb[1] <= 1'b1;
    @(posedge core_clk);
    va_lsb[1] <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("noload va exit", {29'h0, noload_ph}, 32'h5);
    eam_host_inst.wr(ADR_VANL, 32'h0);
    sample();
    chk("noload off", {29'h0, noload_ph}, 32'h0);
    rchk("phase off", ADR_NLPH, 32'h0);
    wrap_up();
  end
endmodule
